/* core/rate_wrap_ctrl.sv */
// Rate select, recovery lock, loopback routing and equalization control for a multi-rate transceiver.
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "rate_wrap_defines.svh"
module rate_wrap_ctrl
  import rate_wrap_pkg::*;
#(
  parameter int LOCK_CYCLES = `LOCK_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Rate select pins, pulled low when open
  input wire logic rx_rate_sel,
  input wire logic tx_rate_sel,
  // Traffic qualifiers from the analog front ends
  input wire logic rx_full_rate_seen,
  input wire logic tx_full_rate_seen,
  // Optical receive stream
  input wire logic optical_rx_bit,
  input wire logic optical_rx_valid,
  output logic optical_rx_ready,
  // Host serial input stream
  input wire logic host_serial_in,
  input wire logic host_serial_valid,
  output logic host_serial_ready,
  // Host serial output stream
  output logic host_serial_out,
  output logic host_serial_out_valid,
  input wire logic host_serial_out_ready,
  // Optical transmit data
  output logic optical_tx_out,
  // Path status
  output logic rx_cdr_engaged,
  output logic tx_cdr_engaged,
  output logic rx_cdr_lock,
  output logic tx_cdr_lock,
  output logic [7:0] eq_setting,
  output logic [7:0] emph_setting,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);
  localparam int CW = $clog2(LOCK_CYCLES + 1);

  logic [7:0] ctrl_ff;
  logic [7:0] eq_ff;
  logic [7:0] emph_ff;
  logic [7:0] reg_rdata_ff;
  logic [1:0] state_ff [2];
  logic [CW-1:0] cnt_ff [2];
  logic [1:0] lock_ff;
  logic [1:0] engaged_ff;
  logic host_out_ff;
  logic host_out_valid_ff;
  logic opt_out_ff;

  // Index 0 is the receive direction, index 1 the transmit direction.
  wire [1:0] rate_sel = {tx_rate_sel, rx_rate_sel};
  wire [1:0] full_seen = {tx_full_rate_seen, rx_full_rate_seen};

  // Each direction waits for a full lock time of qualified traffic before
  // declaring lock; slower-coded traffic never qualifies, so it never locks.
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_cdr
      cdr_state_type cur;
      cdr_state_type nxt;
      logic [CW-1:0] nxt_cnt;
      assign cur = cdr_state_type'(state_ff[g]);
      always_comb begin
        nxt = cur;
        nxt_cnt = cnt_ff[g];
        case (cur)
          cdr_bypass: begin
            nxt_cnt = '0;
            if (rate_sel[g]) begin
              nxt = cdr_search;
            end
          end
          cdr_search: begin
            if (!rate_sel[g]) begin
              nxt = cdr_bypass;
            end else if (!full_seen[g]) begin
              nxt_cnt = '0;
            end else if (cnt_ff[g] == CW'(LOCK_CYCLES - 1)) begin
              nxt = cdr_locked;
            end else begin
              nxt_cnt = cnt_ff[g] + CW'(1);
            end
          end
          cdr_locked: begin
            nxt_cnt = '0;
            if (!rate_sel[g]) begin
              nxt = cdr_bypass;
            end else if (!full_seen[g]) begin
              nxt = cdr_search;
            end
          end
          default: nxt = cdr_bypass;
        endcase
      end
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          state_ff[g] <= 2'(cdr_bypass);
          cnt_ff[g] <= '0;
          lock_ff[g] <= 1'b0;
          engaged_ff[g] <= 1'b0;
        end else begin
          state_ff[g] <= 2'(nxt);
          cnt_ff[g] <= nxt_cnt;
          lock_ff[g] <= (nxt == cdr_locked);
          engaged_ff[g] <= (nxt != cdr_bypass);
        end
      end
    end
  endgenerate

  // Register decode.
  wire wr_ctrl = reg_wr && (reg_addr == `ADDR_CTRL);
  wire wr_eq = reg_wr && (reg_addr == `ADDR_EQ);
  wire wr_emph = reg_wr && (reg_addr == `ADDR_EMPH);
  wire optical_loopback = ctrl_ff[`CTRL_OPTICAL_LOOPBACK_BIT];
  wire electrical_loopback = ctrl_ff[`CTRL_ELECTRICAL_LOOPBACK_BIT];
  wire pass_thru = ctrl_ff[`CTRL_PASS_BIT];
  logic [7:0] rd_sel;
  always_comb begin
    if (reg_addr == `ADDR_CTRL) begin
      rd_sel = {5'h00, ctrl_ff[2:0]};
    end else if (reg_addr == `ADDR_EQ) begin
      rd_sel = eq_ff;
    end else if (reg_addr == `ADDR_EMPH) begin
      rd_sel = emph_ff;
    end else if (reg_addr == `ADDR_STATUS) begin
      rd_sel = {4'h0, engaged_ff[1], engaged_ff[0], lock_ff[1], lock_ff[0]};
    end else begin
      rd_sel = 8'h00;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_ff <= `CTRL_RESET;
      eq_ff <= `EQ_RESET;
      emph_ff <= `EMPH_RESET;
      reg_rdata_ff <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= {5'h00, reg_wdata[2:0]};
      end
      if (wr_eq) begin
        eq_ff <= reg_wdata;
      end
      if (wr_emph) begin
        emph_ff <= reg_wdata;
      end
      reg_rdata_ff <= reg_rd ? rd_sel : 8'h00;
    end
  end

  // Host-bound stream: received optical data normally, host data in electrical loopback.
  // The buffer lets the host stall without losing a bit.
  wire host_src_bit = electrical_loopback ? host_serial_in : optical_rx_bit;
  wire host_src_valid = electrical_loopback ? host_serial_valid : optical_rx_valid;
  wire buf_in_ready;
  wire buf_out_bit;
  wire buf_out_valid;
  wire buf_out_ready = !host_out_valid_ff || host_serial_out_ready;
  // The port ready is a register, so it must promise room one cycle ahead: the fill level
  // is rebuilt from the buffer's flags and advanced by this cycle's moves. A ready that
  // merely copied the buffer's flag would lag by a cycle and drop a bit into a full buffer.
  wire [1:0] buf_level = !buf_out_valid ? 2'h0 : (buf_in_ready ? 2'h1 : 2'h2);
  wire src_ready = electrical_loopback ? host_serial_ready : optical_rx_ready;
  wire buf_push = host_src_valid && src_ready;
  wire buf_pop = buf_out_valid && buf_out_ready;
  wire [1:0] nxt_level = buf_level + {1'b0, buf_push} - {1'b0, buf_pop};
  wire buf_room = (nxt_level != 2'h2);
  // The readies are judged against the mode that holds in the cycle they are seen.
  wire nxt_electrical_loopback = wr_ctrl ? reg_wdata[`CTRL_ELECTRICAL_LOOPBACK_BIT] : electrical_loopback;

  skid_buffer #(
    .WIDTH(1)
  ) skid_buffer_i (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .in_data(host_src_bit),
    .in_valid(buf_push),
    .in_ready(buf_in_ready),
    .out_data(buf_out_bit),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready)
  );

  // Optical transmit: host data normally, received data in optical loopback.
  // In electrical loopback the host data go out optically only when passed through.
  wire opt_src = optical_loopback ? optical_rx_bit : host_serial_in;
  wire opt_en = optical_loopback || !electrical_loopback || pass_thru;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      host_out_ff <= 1'b0;
      host_out_valid_ff <= 1'b0;
      opt_out_ff <= 1'b0;
      optical_rx_ready <= 1'b0;
      host_serial_ready <= 1'b0;
    end else begin
      if (buf_out_ready) begin
        host_out_valid_ff <= buf_out_valid && (!optical_loopback || electrical_loopback || pass_thru);
        host_out_ff <= buf_out_bit;
      end
      opt_out_ff <= opt_en ? opt_src : 1'b0;
      // In electrical loopback the optical stream is taken and dropped.
      optical_rx_ready <= nxt_electrical_loopback ? 1'b1 : buf_room;
      host_serial_ready <= nxt_electrical_loopback ? buf_room : 1'b1;
    end
  end

  assign host_serial_out = host_out_ff;
  assign host_serial_out_valid = host_out_valid_ff;
  assign optical_tx_out = opt_out_ff;
  assign rx_cdr_engaged = engaged_ff[0];
  assign tx_cdr_engaged = engaged_ff[1];
  assign rx_cdr_lock = lock_ff[0];
  assign tx_cdr_lock = lock_ff[1];
  assign eq_setting = eq_ff;
  assign emph_setting = emph_ff;
  assign reg_rdata = reg_rdata_ff;
endmodule

/* core/rate_wrap_defines.svh */
// Offsets, field positions, reset values and timing counts for the rate select and wrap control block.
`ifndef RATE_WRAP_DEFINES_SVH
`define RATE_WRAP_DEFINES_SVH

`define ADDR_CTRL 4'h0
`define ADDR_EQ 4'h1
`define ADDR_EMPH 4'h2
`define ADDR_STATUS 4'h3

`define CTRL_OPTICAL_LOOPBACK_BIT 0
`define CTRL_ELECTRICAL_LOOPBACK_BIT 1
`define CTRL_PASS_BIT 2

`define CTRL_RESET 8'h00
`define EQ_RESET 8'h00
`define EMPH_RESET 8'h00

`define CLK_MHZ 40
`define LOCK_TIME_US 500
`define LOCK_CYCLES (`LOCK_TIME_US * `CLK_MHZ)

`endif

/* core/rate_wrap_pkg.sv */
// Types shared by the rate select and wrap control block.
package rate_wrap_pkg;
  typedef enum logic [1:0] {
    cdr_bypass,
    cdr_search,
    cdr_locked
  } cdr_state_type;
endpackage

/* core/skid_buffer.sv */
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
module skid_buffer #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  logic [WIDTH-1:0] mem_ff [2];
  logic wr_ptr_ff;
  logic rd_ptr_ff;
  logic [1:0] count_ff;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (count_ff != 2'h2);
  assign out_valid = (count_ff != 2'h0);
  assign out_data = mem_ff[rd_ptr_ff];

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      count_ff <= 2'h0;
      mem_ff[0] <= '0;
      mem_ff[1] <= '0;
    end else begin
      if (push) begin
        mem_ff[wr_ptr_ff] <= in_data;
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (pop) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
      count_ff <= count_ff + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

/* test/host_model.sv */
// Host partner: feeds the host serial input and checks the looped stream.
`timescale 1ns/1ps
module host_model (
  // Clock and bench control
  input wire logic core_clk,
  input wire logic stall,
  input wire logic loop_chk,
  // Host serial input stream
  output logic host_serial_in = 1'b0,
  output logic host_serial_valid = 1'b0,
  input wire logic host_serial_ready,
  // Host-bound stream
  input wire logic host_serial_out,
  input wire logic host_serial_out_valid,
  output logic host_serial_out_ready = 1'b0,
  // Tallies
  output int got = 0,
  output int bad = 0
);
  logic [4:0] pat = 5'h01;
  logic q[$];
  always @(posedge core_clk) begin
    pat <= {pat[3:0], pat[4] ^ pat[2]};
    // Ready drops on a pattern so the host-bound path sees stalls.
    host_serial_out_ready <= !stall && pat[1:0] != 2'h0;
    // A word once offered stays offered until it is taken.
    host_serial_valid <= loop_chk || (host_serial_valid && !host_serial_ready);
    if (host_serial_valid && host_serial_ready) begin
      q.push_back(host_serial_in);
      host_serial_in <= pat[4];
    end else if (!host_serial_valid) begin
      // A released line must not keep showing its last bit.
      host_serial_in <= !host_serial_in;
    end
    if (host_serial_out_valid && host_serial_out_ready && q.size() > 0) begin
      got <= got + 1;
      bad <= bad + (host_serial_out !== q.pop_front());
    end
  end
endmodule

/* test/rate_wrap_ctrl_assertions.sv */
// Port-level checks for the rate select and wrap control block.
`timescale 1ns/1ps
`include "rate_wrap_defines.svh"
module rate_wrap_chk #(
  parameter int LOCK_CYCLES = `LOCK_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Rate pins and traffic
  input wire logic rx_rate_sel,
  input wire logic tx_rate_sel,
  input wire logic rx_full_rate_seen,
  // Status
  input wire logic rx_cdr_engaged,
  input wire logic tx_cdr_engaged,
  input wire logic rx_cdr_lock,
  input wire logic tx_cdr_lock,
  input wire logic [7:0] eq_setting,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  // The run of qualified receive traffic is counted here, since a lock time of
  // thousands of cycles cannot be unrolled as a repetition.
  int qual_run;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      qual_run <= 0;
    end else if (!(rx_rate_sel && rx_full_rate_seen)) begin
      qual_run <= 0;
    end else if (qual_run <= LOCK_CYCLES) begin
      qual_run <= qual_run + 1;
    end
  end
  // One cycle more than the lock count covers the engage step from bypass.
  sequence rx_run_done;
    qual_run > LOCK_CYCLES;
  endsequence
  sequence rx_run_short;
    qual_run < LOCK_CYCLES;
  endsequence
  rx_eng_a: assert property (rx_rate_sel |=> rx_cdr_engaged)
    else $error("rx not engaged");
  tx_eng_a: assert property (tx_rate_sel |=> tx_cdr_engaged)
    else $error("tx not engaged");
  rx_bypass_a: assert property (!rx_rate_sel |=> !rx_cdr_engaged && !rx_cdr_lock)
    else $error("rx not bypassed");
  tx_bypass_a: assert property (!tx_rate_sel |=> !tx_cdr_engaged && !tx_cdr_lock)
    else $error("tx not bypassed");
  rx_drop_a: assert property (!rx_full_rate_seen |=> !rx_cdr_lock)
    else $error("rx lock without traffic");
  rx_lock_a: assert property (rx_run_done |-> rx_cdr_lock)
    else $error("rx lock late");
  rx_early_a: assert property (rx_run_short |-> !rx_cdr_lock)
    else $error("rx lock before a full run");
  rd_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read");
  eq_write_a: assert property (reg_wr && reg_addr == 4'h1 |=> eq_setting == $past(reg_wdata))
    else $error("eq not written");
endmodule
bind rate_wrap_ctrl rate_wrap_chk #(.LOCK_CYCLES(LOCK_CYCLES)) rate_wrap_chk_i (.core_clk, .sys_rst, .rx_rate_sel,
  .tx_rate_sel, .rx_full_rate_seen, .rx_cdr_engaged, .tx_cdr_engaged, .rx_cdr_lock, .tx_cdr_lock, .eq_setting,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

/* test/tb.sv */
// Self-checking bench for the rate select and wrap control block.
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0, sys_rst = 1'b1, stall = 1'b0, loop_chk = 1'b0, optical_rx_bit = 1'b0;
  logic rx_rate_sel = 1'b0, tx_rate_sel = 1'b0, rx_full_rate_seen = 1'b0, tx_full_rate_seen = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, optical_rx_ready;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] eq_setting, emph_setting, reg_rdata;
  logic host_serial_in, host_serial_valid, host_serial_ready, host_serial_out, host_serial_out_valid;
  logic host_serial_out_ready, optical_tx_out, rx_cdr_engaged, tx_cdr_engaged, rx_cdr_lock, tx_cdr_lock;
  int num_errors = 0, comparisons = 0, cyc = 0, got, bad;
  rate_wrap_ctrl #(.LOCK_CYCLES(8)) rate_wrap_ctrl_i (.core_clk, .sys_rst, .rx_rate_sel, .tx_rate_sel,
    .rx_full_rate_seen, .tx_full_rate_seen, .optical_rx_bit, .optical_rx_valid(1'b1), .optical_rx_ready,
    .host_serial_in, .host_serial_valid, .host_serial_ready, .host_serial_out, .host_serial_out_valid,
    .host_serial_out_ready, .optical_tx_out, .rx_cdr_engaged, .tx_cdr_engaged, .rx_cdr_lock, .tx_cdr_lock,
    .eq_setting, .emph_setting, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  host_model host_model_i (.core_clk, .stall, .loop_chk, .host_serial_in, .host_serial_valid,
    .host_serial_ready, .host_serial_out, .host_serial_out_valid, .host_serial_out_ready, .got, .bad);
  initial forever #12.5 core_clk = ~core_clk;
  task automatic end_sim();
    $display("errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge core_clk) begin
    optical_rx_bit <= cyc[0] ^ cyc[3];
    cyc++;
    if (cyc > 3000) begin
      num_errors++;
      end_sim();
    end
  end
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // Order is tx rate, rx rate, tx traffic, rx traffic; status is read after n cycles.
  task automatic rate(logic [3:0] v, int n, logic [7:0] e);
    @(posedge core_clk);
    {tx_rate_sel, rx_rate_sel, tx_full_rate_seen, rx_full_rate_seen} <= v;
    repeat (n) @(posedge core_clk);
    rd(4'h3, e);
  endtask
  // Source 0 is the optical receive bit, 1 the host input, 2 a gated output.
  task automatic tx_chk(int m);
    logic b;
    repeat (8) begin
      @(posedge core_clk);
      #1 b = m == 0 ? optical_rx_bit : m == 1 ? host_serial_in : 1'b0;
      @(posedge core_clk);
      #1 chk(optical_tx_out, b);
    end
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(4'h3, 8'h00);
    wr(4'h0, 8'hFF);
    wr(4'hF, 8'h5A);
    rd(4'h0, 8'h07);
    rd(4'hF, 8'h00);
    wr(4'h1, 8'hA5);
    wr(4'h2, 8'h3C);
    rd(4'h1, 8'hA5);
    rd(4'h2, 8'h3C);
    chk(emph_setting, 8'h3C);
    rate(4'h4, 20, 8'h04);
    rate(4'h5, 3, 8'h04);
    rate(4'h5, 20, 8'h05);
    rate(4'h4, 2, 8'h04);
    rate(4'hF, 20, 8'h0F);
    rate(4'h3, 2, 8'h00);
    wr(4'h0, 8'h01);
    tx_chk(0);
    #1 chk(host_serial_out_valid, 1'b0);
    wr(4'h0, 8'h05);
    repeat (8) @(posedge core_clk);
    #1 chk(host_serial_out_valid, 1'b1);
    wr(4'h0, 8'h02);
    tx_chk(2);
    @(posedge core_clk);
    loop_chk <= 1'b1;
    stall <= 1'b1;
    repeat (30) @(posedge core_clk);
    #1 chk(host_serial_ready, 1'b0);
    chk(optical_rx_ready, 1'b1);
    @(posedge core_clk);
    stall <= 1'b0;
    repeat (100) @(posedge core_clk);
    wr(4'h0, 8'h06);
    tx_chk(1);
    @(posedge core_clk);
    loop_chk <= 1'b0;
    repeat (20) @(posedge core_clk);
    chk(bad != 0, 8'h00);
    chk(got > 40, 8'h01);
    end_sim();
  end
endmodule
